// ==== shared/cmt_defines.svh ====
// register offsets, field positions and reset values of the timer
`ifndef CMT_DEFINES_SVH
`define CMT_DEFINES_SVH
`define CMT_OFS_STAT 8'h00
`define CMT_OFS_CLR 8'h04
`define CMT_OFS_EN 8'h08
`define CMT_OFS_CTRL 8'h0c
`define CMT_OFS_TC 8'h10
`define CMT_OFS_PR 8'h14
`define CMT_OFS_PC 8'h18
`define CMT_OFS_MODE 8'h1c
`define CMT_OFS_MCTL 8'h20
`define CMT_OFS_CCTL 8'h24
`define CMT_OFS_EXT 8'h28
`define CMT_OFS_ROUTE 8'h2c
`define CMT_OFS_MR0 8'h30
`define CMT_OFS_MR1 8'h34
`define CMT_OFS_CR0 8'h40
`define CMT_CTRL_EN 0
`define CMT_CTRL_HOLD 1
`define CMT_MODE_SEL_LSB 2
`define CMT_MCTL_STOP_LSB 4
`define CMT_CCTL_FALL_LSB 4
`define CMT_EXT_ACT_LSB 4
`define CMT_ROUTE_AND_LSB 8
`define CMT_ROUTE_BC_LSB 12
`define CMT_ROUTE_RST 32'h0fa5_0055
`define CMT_RESP_OKAY 2'h0
`define CMT_RESP_SLVERR 2'h2
`endif

// ==== shared/cmt_pkg.sv ====
// types shared by the timer files
`default_nettype none
package cmt_pkg;
   // count source, field order gives the register code
   typedef enum logic [1:0] {SRC_TIMER, SRC_RISE, SRC_FALL, SRC_BOTH} cmt_src_e;
   // external output action on match
   typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} cmt_act_e;
   // event vector, same layout in status, clear and enable
   typedef struct packed
   {
      logic [3:0] cap;
      logic [3:0] mat;
   } cmt_irq_s;
   // match configuration
   typedef struct packed
   {
      logic [3:0] stop;
      logic [3:0] rst;
   } cmt_mctl_s;
endpackage : cmt_pkg
`default_nettype wire

// ==== core/cmt_cap_input.sv ====
// one capture channel input: pin sync, pin combining, edge pulses
`default_nettype none
module cmt_cap_input #(
   parameter int PINS = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // pins and routing
   input wire logic [PINS-1:0] pins,
   input wire logic [PINS-1:0] mask,
   input wire logic and_mode,
   // combined level and edges
   output logic level,
   output logic rise,
   output logic fall
);
   logic [PINS-1:0] meta_q;
   logic [PINS-1:0] sync_q;
   logic comb_q;
   logic comb_d;

   // unmasked pins count as high for and, low for or
   assign comb_d = and_mode ? &(sync_q | ~mask) : |(sync_q & mask);
   assign level = comb_q;
   assign rise = comb_d & ~comb_q;
   assign fall = ~comb_d & comb_q;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
         comb_q <= 1'b0;
      end
      else
      begin
         meta_q <= pins;
         sync_q <= meta_q;
         comb_q <= comb_d;
      end
   end
endmodule : cmt_cap_input
`default_nettype wire

// ==== core/cmt_timer.sv ====
// capture and match timer with axi4-lite registers
// Functional notes
// - 32-bit counter advances once per prescaler wrap
// - timer mode counts every clock cycle, events on chosen values
// - four 32-bit capture registers latch the count on input edges
// - capture raises the interrupt only when enabled for that channel
// - four match registers may stop or reset the count, with interrupt
// - four match outputs go low, high, toggle or hold on match
// - count source is the clock or an external capture-pin clock
// - counter mode selects exactly one capture channel as clock
// - several pins may feed one capture channel, and several match pins may follow one match output
`include "cmt_defines.svh"
`default_nettype none
module cmt_timer #(
   parameter int PINS = 2
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // axi4-lite write
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // pins
   input wire logic [4*PINS-1:0] CAP_PIN,
   output logic [4*PINS-1:0] MATCH_PIN,
   output logic IRQ
);
   localparam int NP = 4 * PINS;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[8*b +: 8] = data[8*b +: 8];
      return r;
   endfunction : merge

   // bus state
   logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q, rd_mux;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic rd_ok;
   // timer state
   logic [31:0] tc_q, pr_q, pc_q, ctrl_q, mode_q, route_q;
   logic [31:0] mr_q [4];
   logic [31:0] cap_q [4];
   cmt_pkg::cmt_irq_s stat_q, en_q, ev;
   cmt_pkg::cmt_mctl_s mctl_q;
   logic [7:0] cctl_q;
   logic [3:0] ext_q, ext_d;
   logic [7:0] act_q;
   logic [NP-1:0] match_pin_q;
   logic [3:0] ch_rise, ch_fall, ch_level, cap_ev, match_ev;

   wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
   wire [31:0] wmask = merge(32'h0000_0000, 32'hffff_ffff, wstrb_q);
   wire wr_clr = do_wr && awaddr_q == `CMT_OFS_CLR;
   wire wr_en = do_wr && awaddr_q == `CMT_OFS_EN;
   wire wr_ctrl = do_wr && awaddr_q == `CMT_OFS_CTRL;
   wire wr_tc = do_wr && awaddr_q == `CMT_OFS_TC;
   wire wr_pr = do_wr && awaddr_q == `CMT_OFS_PR;
   wire wr_pc = do_wr && awaddr_q == `CMT_OFS_PC;
   wire wr_mode = do_wr && awaddr_q == `CMT_OFS_MODE;
   wire wr_mctl = do_wr && awaddr_q == `CMT_OFS_MCTL;
   wire wr_cctl = do_wr && awaddr_q == `CMT_OFS_CCTL;
   wire wr_ext = do_wr && awaddr_q == `CMT_OFS_EXT;
   wire wr_route = do_wr && awaddr_q == `CMT_OFS_ROUTE;
   wire wr_known = wr_clr | wr_en | wr_ctrl | wr_tc | wr_pr | wr_pc
      | wr_mode | wr_mctl | wr_cctl | wr_ext | wr_route
      | (awaddr_q[7:4] == `CMT_OFS_MR0 >> 4 && awaddr_q[1:0] == 2'h0);
   wire [31:0] wval = wdata_q & wmask;

   assign S_AXI_AWREADY = ~aw_full_q;
   assign S_AXI_WREADY = ~w_full_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = ~rvalid_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   // read decode, unmapped offsets answer slverr with zero data
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      if (S_AXI_ARADDR == `CMT_OFS_STAT)
         rd_mux = {24'h00_0000, stat_q};
      else if (S_AXI_ARADDR == `CMT_OFS_CLR)
         rd_mux = 32'h0000_0000;
      else if (S_AXI_ARADDR == `CMT_OFS_EN)
         rd_mux = {24'h00_0000, en_q};
      else if (S_AXI_ARADDR == `CMT_OFS_CTRL)
         rd_mux = ctrl_q;
      else if (S_AXI_ARADDR == `CMT_OFS_TC)
         rd_mux = tc_q;
      else if (S_AXI_ARADDR == `CMT_OFS_PR)
         rd_mux = pr_q;
      else if (S_AXI_ARADDR == `CMT_OFS_PC)
         rd_mux = pc_q;
      else if (S_AXI_ARADDR == `CMT_OFS_MODE)
         rd_mux = mode_q;
      else if (S_AXI_ARADDR == `CMT_OFS_MCTL)
         rd_mux = {24'h00_0000, mctl_q};
      else if (S_AXI_ARADDR == `CMT_OFS_CCTL)
         rd_mux = {24'h00_0000, cctl_q};
      else if (S_AXI_ARADDR == `CMT_OFS_EXT)
         rd_mux = {20'h0_0000, act_q, ext_q};
      else if (S_AXI_ARADDR == `CMT_OFS_ROUTE)
         rd_mux = route_q;
      else if (S_AXI_ARADDR[7:4] == `CMT_OFS_MR0 >> 4
         && S_AXI_ARADDR[1:0] == 2'h0)
         rd_mux = mr_q[S_AXI_ARADDR[3:2]];
      else if (S_AXI_ARADDR[7:4] == `CMT_OFS_CR0 >> 4
         && S_AXI_ARADDR[1:0] == 2'h0)
         rd_mux = cap_q[S_AXI_ARADDR[3:2]];
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= `CMT_RESP_OKAY;
         rresp_q <= `CMT_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         if (S_AXI_AWVALID && !aw_full_q)
         begin
            aw_full_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_full_q)
         begin
            w_full_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
         if (do_wr)
         begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? `CMT_RESP_OKAY : `CMT_RESP_SLVERR;
         end
         else if (S_AXI_BREADY)
            bvalid_q <= 1'b0;
         if (S_AXI_ARVALID && !rvalid_q)
         begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? `CMT_RESP_OKAY : `CMT_RESP_SLVERR;
         end
         else if (S_AXI_RREADY)
            rvalid_q <= 1'b0;
      end
   end

   // capture channel inputs, each fed by a group of pins
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_cap
         cmt_cap_input #(.PINS(PINS)) u_in (
            .clock(CLOCK),
            .rst(SYS_RST),
            .pins(CAP_PIN[g*PINS +: PINS]),
            .mask(route_q[g*PINS +: PINS]),
            .and_mode(route_q[`CMT_ROUTE_AND_LSB + g]),
            .level(ch_level[g]),
            .rise(ch_rise[g]),
            .fall(ch_fall[g])
         );
      end
   endgenerate

   // count source
   wire cmt_pkg::cmt_src_e src = cmt_pkg::cmt_src_e'(mode_q[1:0]);
   wire [1:0] sel = mode_q[`CMT_MODE_SEL_LSB +: 2];
   wire ext_edge = (src == cmt_pkg::SRC_RISE && ch_rise[sel])
      || (src == cmt_pkg::SRC_FALL && ch_fall[sel])
      || (src == cmt_pkg::SRC_BOTH && (ch_rise[sel] | ch_fall[sel]));
   wire run = ctrl_q[`CMT_CTRL_EN] & ~ctrl_q[`CMT_CTRL_HOLD];
   wire tick = run && (src == cmt_pkg::SRC_TIMER || ext_edge);
   wire adv = tick && pc_q == pr_q;
   generate
      for (g = 0; g < 4; g++)
      begin : g_ev
         assign match_ev[g] = adv && tc_q == mr_q[g];
         // the channel clocking the counter captures nothing
         assign cap_ev[g] = (src == cmt_pkg::SRC_TIMER || sel != g)
            && ((ch_rise[g] && cctl_q[g])
            || (ch_fall[g] && cctl_q[`CMT_CCTL_FALL_LSB + g]));
         always_comb
         begin
            case (cmt_pkg::cmt_act_e'(act_q[2*g +: 2]))
               cmt_pkg::ACT_LOW: ext_d[g] = match_ev[g] ? 1'b0 : ext_q[g];
               cmt_pkg::ACT_HIGH: ext_d[g] = match_ev[g] | ext_q[g];
               cmt_pkg::ACT_TOGGLE: ext_d[g] = match_ev[g] ^ ext_q[g];
               default: ext_d[g] = ext_q[g];
            endcase
         end
      end
   endgenerate
   assign ev = '{cap: cap_ev, mat: match_ev};
   wire any_rst = |(match_ev & mctl_q.rst);
   wire any_stop = |(match_ev & mctl_q.stop);
   assign IRQ = |(stat_q & en_q);
   assign MATCH_PIN = match_pin_q;

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         tc_q <= 32'h0000_0000;
         pc_q <= 32'h0000_0000;
         pr_q <= 32'h0000_0000;
         ctrl_q <= 32'h0000_0000;
         mode_q <= 32'h0000_0000;
         route_q <= `CMT_ROUTE_RST;
         stat_q <= '0;
         en_q <= '0;
         mctl_q <= '0;
         cctl_q <= 8'h00;
         act_q <= 8'h00;
         ext_q <= 4'h0;
         match_pin_q <= '0;
         for (int i = 0; i < 4; i++)
         begin
            mr_q[i] <= 32'h0000_0000;
            cap_q[i] <= 32'h0000_0000;
         end
      end
      else
      begin
         // hold forces zero; a match reset beats the increment
         if (ctrl_q[`CMT_CTRL_HOLD])
            tc_q <= 32'h0000_0000;
         else if (wr_tc)
            tc_q <= merge(tc_q, wdata_q, wstrb_q);
         else if (any_rst)
            tc_q <= 32'h0000_0000;
         else if (adv)
            tc_q <= tc_q + 32'h0000_0001;
         if (ctrl_q[`CMT_CTRL_HOLD])
            pc_q <= 32'h0000_0000;
         else if (wr_pc)
            pc_q <= merge(pc_q, wdata_q, wstrb_q);
         else if (adv)
            pc_q <= 32'h0000_0000;
         else if (tick)
            pc_q <= pc_q + 32'h0000_0001;
         // a stop match beats a concurrent software write
         if (wr_ctrl)
            ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0003;
         if (any_stop)
            ctrl_q[`CMT_CTRL_EN] <= 1'b0;
         if (wr_pr)
            pr_q <= merge(pr_q, wdata_q, wstrb_q);
         if (wr_mode)
            mode_q <= merge(mode_q, wdata_q, wstrb_q) & 32'h0000_000f;
         if (wr_route)
            route_q <= merge(route_q, wdata_q, wstrb_q) & 32'h0fff_ffff;
         if (wr_en)
            en_q <= wval[7:0];
         if (wr_mctl)
            mctl_q <= wval[7:0];
         if (wr_cctl)
            cctl_q <= wval[7:0];
         if (wr_ext)
            act_q <= wval[11:4];
         // set wins over clear
         stat_q <= (stat_q & ~(wr_clr ? wval[7:0] : 8'h00)) | ev;
         ext_q <= wr_ext ? (wval[3:0] | (ext_q & ~wmask[3:0])) : ext_d;
         for (int p = 0; p < NP; p++)
            match_pin_q[p] <= ext_q[route_q[`CMT_ROUTE_BC_LSB + 2*p +: 2]];
         for (int i = 0; i < 4; i++)
         begin
            if (do_wr && awaddr_q == `CMT_OFS_MR0 + 8'(4*i))
               mr_q[i] <= merge(mr_q[i], wdata_q, wstrb_q);
            if (cap_ev[i])
               cap_q[i] <= tc_q;
         end
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   sequence s_wrap;
      adv && !wr_pc && !ctrl_q[`CMT_CTRL_HOLD];
   endsequence
   sequence s_cleared;
      pc_q == 32'h0000_0000;
   endsequence
   property p_prescale_wrap;
      s_wrap |=> s_cleared;
   endproperty
   a_prescale_wrap: assert property (p_prescale_wrap)
      else $error("prescaler did not wrap to zero");
   property p_count_adv;
      adv && !any_rst && !wr_tc && !ctrl_q[`CMT_CTRL_HOLD]
         |=> tc_q == $past(tc_q) + 32'h0000_0001;
   endproperty
   a_count_adv: assert property (p_count_adv)
      else $error("counter did not advance on prescaler wrap");
   property p_timer_tick;
      run && src == cmt_pkg::SRC_TIMER |-> tick;
   endproperty
   a_timer_tick: assert property (p_timer_tick)
      else $error("timer mode missed a clock cycle");
   property p_ext_tick;
      run && src == cmt_pkg::SRC_RISE |-> tick == ch_rise[sel];
   endproperty
   a_ext_tick: assert property (p_ext_tick)
      else $error("external clock edge not counted");
   property p_capture;
      cap_ev[0] |=> cap_q[0] == $past(tc_q);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture did not hold the count");
   property p_cap_irq;
      |(cap_ev & en_q.cap) |=> IRQ;
   endproperty
   a_cap_irq: assert property (p_cap_irq)
      else $error("enabled capture did not interrupt");
   property p_match_reset;
      any_rst && !wr_tc |=> tc_q == 32'h0000_0000;
   endproperty
   a_match_reset: assert property (p_match_reset)
      else $error("match reset did not clear the count");
   property p_match_stop;
      any_stop |=> !ctrl_q[`CMT_CTRL_EN] ##1 !adv;
   endproperty
   a_match_stop: assert property (p_match_stop)
      else $error("match stop left the counter running");
   property p_toggle;
      match_ev[0] && act_q[1:0] == 2'h3 && !wr_ext
         |=> ext_q[0] != $past(ext_q[0]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("match output did not toggle");
endmodule : cmt_timer
`default_nettype wire

// ==== tb/cmt_pin_model.sv ====
// pin-side model: capture pins as an external clock or event source
`default_nettype none
module cmt_pin_model (
   // clock
   input wire logic clock,
   // requests from the bench
   input wire logic [2:0] sel,
   input wire logic [7:0] count,
   input wire logic [3:0] half,
   input wire logic start,
   // pin side
   output logic busy,
   output logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   int h;
   initial
   begin
      pins = 8'h00;
      busy = 1'b0;
      forever
      begin
         @(posedge clock);
         if (start === 1'b1)
         begin
            // two cycles a level at least, so never above a quarter rate
            h = (half < 4'h2) ? 2 : int'(half);
            busy <= 1'b1;
            repeat (count)
            begin
               pins[sel] <= 1'b1;
               repeat (h) @(posedge clock);
               pins[sel] <= 1'b0;
               repeat (h) @(posedge clock);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule : cmt_pin_model
`default_nettype wire

// ==== tb/cmt_timer_tb.sv ====
// self-checking bench of the capture and match timer
`include "cmt_defines.svh"
`default_nettype none
module cmt_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [7:0] S_AXI_AWADDR = 8'h00;
   logic [7:0] S_AXI_ARADDR = 8'h00;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic [3:0] S_AXI_WSTRB = 4'h0;
   logic S_AXI_AWVALID = 1'b0;
   logic S_AXI_WVALID = 1'b0;
   logic S_AXI_ARVALID = 1'b0;
   logic S_AXI_BREADY = 1'b1;
   logic S_AXI_RREADY = 1'b1;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_ARREADY, S_AXI_RVALID, IRQ, pm_busy;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [31:0] S_AXI_RDATA;
   logic [7:0] CAP_PIN, MATCH_PIN;
   logic [2:0] pm_sel = 3'h0;
   logic [7:0] pm_count = 8'h00;
   logic [3:0] pm_half = 4'h2;
   logic pm_start = 1'b0;
   logic [31:0] rng = 32'h0001_1130;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;

   cmt_timer #(.PINS(2)) uut (
      .CLOCK(CLOCK), .SYS_RST(SYS_RST),
      .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
      .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
      .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
      .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
      .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
      .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
      .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
      .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
      .S_AXI_RREADY(S_AXI_RREADY), .CAP_PIN(CAP_PIN),
      .MATCH_PIN(MATCH_PIN), .IRQ(IRQ));

   cmt_pin_model pins_side (.clock(CLOCK), .sel(pm_sel), .count(pm_count),
      .half(pm_half), .start(pm_start), .busy(pm_busy), .pins(CAP_PIN));

   always #2 CLOCK = ~CLOCK;

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : rnd

   function automatic logic act_res(input logic [1:0] a, input logic s);
      return (a == 2'h0) ? s : (a == 2'h1) ? 1'b0 : (a == 2'h2) ? 1'b1 : !s;
   endfunction : act_res

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // each channel dropped once taken; the response closes the write
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
      int t;
      t = 0;
      S_AXI_AWADDR <= a;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= s;
      S_AXI_WVALID <= 1'b1;
      do
      begin
         @(posedge CLOCK);
         t++;
         if (S_AXI_AWVALID === 1'b1 && S_AXI_AWREADY === 1'b1)
            S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WVALID === 1'b1 && S_AXI_WREADY === 1'b1)
            S_AXI_WVALID <= 1'b0;
      end
      while (S_AXI_BVALID !== 1'b1 && t < 200);
      chk("bresp", {30'h0, er}, {30'h0, S_AXI_BRESP});
      if (t >= 200)
         miscompares++;
   endtask : wr

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, 4'hf, `CMT_RESP_OKAY);
   endtask : w

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      input logic [1:0] er);
      int t;
      t = 0;
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do
      begin
         @(posedge CLOCK);
         t++;
         if (S_AXI_ARREADY === 1'b1)
            S_AXI_ARVALID <= 1'b0;
      end
      while (S_AXI_RVALID !== 1'b1 && t < 200);
      d = S_AXI_RDATA;
      chk("rresp", {30'h0, er}, {30'h0, S_AXI_RRESP});
      if (t >= 200)
         miscompares++;
   endtask : rd

   task automatic wait_irq(output int n);
      n = 0;
      while (IRQ !== 1'b1 && n < 4000)
      begin
         @(posedge CLOCK);
         n++;
      end
   endtask : wait_irq

   // pulse train on one capture pin, random speed within the pin limits
   task automatic wiggle(input logic [2:0] p, input logic [7:0] n);
      logic [31:0] v;
      int t;
      v = rnd();
      t = 0;
      pm_sel <= p;
      pm_count <= n;
      pm_half <= 4'h2 + {2'h0, v[1:0]};
      pm_start <= 1'b1;
      @(posedge CLOCK);
      pm_start <= 1'b0;
      do
      begin
         @(posedge CLOCK);
         t++;
      end
      while (pm_busy !== 1'b0 && t < 3000);
      // pin sync and capture load take three cycles
      repeat (6) @(posedge CLOCK);
      if (t >= 3000)
         miscompares++;
   endtask : wiggle

   always @(posedge CLOCK)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         miscompares++;
         wrap_up();
      end
   end

   initial
   begin : main
      logic [31:0] d, t0, p, m, s;
      int n, lo, hi;
      repeat (12) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      @(posedge CLOCK);
      rd(`CMT_OFS_ROUTE, d, `CMT_RESP_OKAY);
      chk("route reset", `CMT_ROUTE_RST, d);
      rd(8'h50, d, `CMT_RESP_SLVERR);
      chk("unmapped read", 32'h0, d);
      wr(8'h54, 32'hffff_ffff, 4'hf, `CMT_RESP_SLVERR);
      w(`CMT_OFS_MR0, 32'h1234_5678);
      wr(`CMT_OFS_MR0, 32'hffff_ffff, 4'h2, `CMT_RESP_OKAY);
      rd(`CMT_OFS_MR0, d, `CMT_RESP_OKAY);
      chk("match strobe", 32'h1234_ff78, d);
      // park the other matches out of reach so only match 0 reports
      for (int k = 1; k < 4; k++)
         w(`CMT_OFS_MR0 + 8'(4 * k), 32'hffff_ffff);
      w(`CMT_OFS_EN, 32'h0000_0001);
      for (int a = 0; a < 4; a++)
      begin
         d = rnd();
         p = {30'h0, d[1:0]};
         m = {29'h0, d[4:2]} + 32'h1;
         s = {31'h0, d[5]};
         w(`CMT_OFS_PR, p);
         w(`CMT_OFS_TC, 32'h0);
         w(`CMT_OFS_PC, 32'h0);
         w(`CMT_OFS_MR0, m);
         w(`CMT_OFS_MCTL, 32'h0000_0010);
         w(`CMT_OFS_EXT, {26'h0, a[1:0], 3'h0, s[0]});
         w(`CMT_OFS_CTRL, 32'h0000_0001);
         wait_irq(n);
         lo = int'(m) * (int'(p) + 1) - 2;
         hi = lo + int'(p) + 6;
         chk("elapsed", 32'h1, {31'h0, n >= lo && n <= hi});
         rd(`CMT_OFS_TC, d, `CMT_RESP_OKAY);
         chk("stop count", m + 32'h1, d);
         rd(`CMT_OFS_CTRL, d, `CMT_RESP_OKAY);
         chk("stop enable", 32'h0, d & 32'h1);
         rd(`CMT_OFS_STAT, d, `CMT_RESP_OKAY);
         chk("match status", 32'h1, d);
         rd(`CMT_OFS_EXT, d, `CMT_RESP_OKAY);
         chk("ext state", {31'h0, act_res(a[1:0], s[0])}, d & 32'h1);
         chk("match pins", {30'h0, {2{act_res(a[1:0], s[0])}}},
            {24'h0, MATCH_PIN});
         w(`CMT_OFS_CLR, 32'h0000_00ff);
         chk("irq cleared", 32'h0, {31'h0, IRQ});
      end
      // reset on match, status set while its interrupt is masked
      w(`CMT_OFS_EN, 32'h0);
      w(`CMT_OFS_MR1, 32'h5);
      w(`CMT_OFS_PR, 32'h0);
      w(`CMT_OFS_TC, 32'h0);
      w(`CMT_OFS_MCTL, 32'h0000_0002);
      w(`CMT_OFS_CTRL, 32'h0000_0001);
      repeat (40) @(posedge CLOCK);
      chk("irq masked", 32'h0, {31'h0, IRQ});
      for (int i = 0; i < 4; i++)
      begin
         rd(`CMT_OFS_TC, d, `CMT_RESP_OKAY);
         chk("count bounded", 32'h1, {31'h0, d <= 32'h5});
      end
      w(`CMT_OFS_EN, 32'h0000_0002);
      chk("irq enabled", 32'h1, {31'h0, IRQ});
      w(`CMT_OFS_CTRL, 32'h0);
      w(`CMT_OFS_CLR, 32'h0000_00ff);
      chk("irq off", 32'h0, {31'h0, IRQ});
      // captures: channel 0 enabled, channel 1 silent
      w(`CMT_OFS_MR0, 32'hffff_ff00);
      w(`CMT_OFS_MR1, 32'hffff_ff00);
      w(`CMT_OFS_MCTL, 32'h0);
      w(`CMT_OFS_CCTL, 32'h0000_0003);
      w(`CMT_OFS_EN, 32'h0000_0010);
      w(`CMT_OFS_CTRL, 32'h0000_0001);
      rd(`CMT_OFS_TC, t0, `CMT_RESP_OKAY);
      wiggle(3'h0, 8'h01);
      rd(`CMT_OFS_CR0, d, `CMT_RESP_OKAY);
      rd(`CMT_OFS_TC, m, `CMT_RESP_OKAY);
      chk("capture window", 32'h1, {31'h0, d > t0 && d < m});
      chk("irq capture", 32'h1, {31'h0, IRQ});
      w(`CMT_OFS_CLR, 32'h0000_00ff);
      wiggle(3'h2, 8'h01);
      rd(`CMT_OFS_STAT, d, `CMT_RESP_OKAY);
      chk("silent status", 32'h20, d);
      chk("irq silent", 32'h0, {31'h0, IRQ});
      rd(`CMT_OFS_CR0 + 8'h04, d, `CMT_RESP_OKAY);
      chk("capture one", 32'h1, {31'h0, d > m});
      // counter mode on channel 1, every edge kind
      w(`CMT_OFS_CTRL, 32'h0);
      w(`CMT_OFS_CCTL, 32'h0);
      for (int md = 1; md < 4; md++)
      begin
         d = rnd();
         n = int'(d[2:0]) + 1;
         w(`CMT_OFS_TC, 32'h0);
         w(`CMT_OFS_PC, 32'h0);
         w(`CMT_OFS_MODE, {28'h0, 2'h1, md[1:0]});
         w(`CMT_OFS_CTRL, 32'h0000_0001);
         wiggle(3'h2, n[7:0]);
         rd(`CMT_OFS_TC, d, `CMT_RESP_OKAY);
         m = (md == 3) ? 32'(2 * n) : 32'(n);
         chk("edge count", m, d);
         wiggle(3'h0, 8'h02);
         rd(`CMT_OFS_TC, d, `CMT_RESP_OKAY);
         chk("other pin", m, d);
      end
      // channel 0 fed by its second pin alone, in and mode
      w(`CMT_OFS_MODE, 32'h0);
      w(`CMT_OFS_CCTL, 32'h0000_0001);
      w(`CMT_OFS_ROUTE, `CMT_ROUTE_RST ^ 32'h0000_0103);
      w(`CMT_OFS_CLR, 32'h0000_00ff);
      wiggle(3'h1, 8'h01);
      rd(`CMT_OFS_STAT, d, `CMT_RESP_OKAY);
      chk("and route", 32'h10, d);
      // hold keeps the count at zero
      w(`CMT_OFS_CTRL, 32'h0000_0003);
      rd(`CMT_OFS_TC, d, `CMT_RESP_OKAY);
      chk("hold count", 32'h0, d);
      wrap_up();
   end
endmodule : cmt_timer_tb
`default_nettype wire
